//--- rap_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and types for the auxiliary register pages.
// ----------------------------------------------------------------------------
package rap_pkg;

  // Register addresses on the internal byte port.
  localparam logic [7:0] ADDR_RELOAD_LOW   = 8'h18;
  localparam logic [7:0] ADDR_RELOAD_HIGH  = 8'h19;
  localparam logic [7:0] ADDR_TEMPERATURE  = 8'h20;
  localparam logic [7:0] ADDR_NV_USER_0    = 8'h28;
  localparam logic [7:0] ADDR_NV_USER_1    = 8'h29;
  localparam logic [7:0] ADDR_NV_CONFIG    = 8'h30;
  localparam logic [7:0] ADDR_XTAL_OFFSET  = 8'h31;
  localparam logic [7:0] ADDR_XTAL_COEF    = 8'h32;
  localparam logic [7:0] ADDR_XTAL_TURN    = 8'h33;
  localparam logic [7:0] ADDR_SCRATCH_BASE = 8'h38;
  localparam logic [7:0] ADDR_SCRATCH_LAST = 8'h3f;

  // Field positions in the configuration byte and the crystal offset byte.
  localparam int CFG_TRICKLE_HI   = 7;
  localparam int CFG_TRICKLE_LO   = 4;
  localparam int CFG_FREQ_HI      = 3;
  localparam int CFG_FREQ_LO      = 2;
  localparam int CFG_THERMO_EN    = 1;
  localparam int CFG_SCAN_SEL     = 0;
  localparam int OFFSET_SIGN_BIT  = 7;

  // Implemented-bit masks; other bits read as zero.
  localparam logic [7:0] TURNOVER_MASK = 8'h3f;

  // Reset values before the non-volatile page is loaded.
  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [7:0] TEMP_OFFSET = 8'h3c;

  // Scan intervals in seconds.
  localparam int SCAN_FAST_S = 1;
  localparam int SCAN_SLOW_S = 16;

  // Power-up sequencing states.
  typedef enum logic [2:0] {
    PWR_WAIT = 3'b001,
    PWR_LOAD = 3'b010,
    PWR_RUN  = 3'b100
  } rap_pwr_e;

  // Host byte access.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       busy;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rap_host_s;

  // Decoded configuration fields.
  typedef struct packed {
    logic [3:0] trickle_res;
    logic [1:0] clock_output_pin_freq;
    logic       thermo_en;
    logic       scan_slow;
  } rap_cfg_s;

  // Compensation parameters.
  typedef struct packed {
    logic       offset_sign;
    logic [6:0] offset_mag;
    logic [7:0] quad_coef;
    logic [5:0] turnover_temp;
  } rap_comp_s;

endpackage : rap_pkg

//--- rap_pages.sv
// Operation
// - Timer reload is a 16-bit value, low byte 18h, high byte 19h.
// - Temperature byte is degrees plus 60, one degree per step.
// - Temperature is cached during a bus access so updates cannot corrupt it.
// - Host writes temperature only while thermometer is disabled.
// - Two non-volatile user bytes at 28h and 29h.
// - Config bits 7..4 enable the 80k, 20k, 5k and 1.5k resistors.
// - Config bits 3..2 select one of four clock output frequencies.
// - Config bit 1 enables the thermometer.
// - Config bit 0 selects 1 s or 16 s temperature scan interval.
// - Crystal offset magnitude sits in bits 6..0, range 0 to 121.
// - Crystal offset bit 7 is the sign, one meaning faster.
// - Crystal coefficient is an 8-bit unsigned quadratic drift value.
// - Turnover temperature in bits 5..0; bits 7..6 unused.
// - Eight volatile user bytes at 38h through 3Fh.
// - Backup supply disables the host interface and clock output.
// - Interrupt stays functional on backup; trickle charge is off.
// - Trickle charge only with a resistor selected, off at switchover.
// - Interrupt on either low-supply threshold only when enabled.
// - Unimplemented bit positions read as zero.
// - After power-up the configuration page loads from non-volatile storage.
// - Below threshold one, thermometer stops and last reading is kept.
`timescale 1ns/10ps

module rap_pages #(
  parameter int SCRATCH_DEPTH = 8                          // Volatile user bytes.
) (
  input  wire logic               mclk_i,                 // 20 MHz clock.
  input  wire logic               sys_rst_i,              // Async reset, high.
  input  wire rap_pkg::rap_host_s host_i,                 // Host byte access.
  output logic [7:0]              rdata_o,                // Read data.
  input  wire logic               backup_mode_i,          // Pin: on backup supply.
  input  wire logic               low_one_i,              // Pin: below threshold one.
  input  wire logic               low_two_i,              // Pin: below threshold two.
  input  wire logic               low_one_int_en_i,       // Threshold one irq enable.
  input  wire logic               low_two_int_en_i,       // Threshold two irq enable.
  input  wire logic               other_irq_i,            // Other interrupt sources.
  input  wire logic               supply_ok_i,            // Pin: supply adequate.
  input  wire logic               nv_load_i,              // Page word valid.
  input  wire logic [39:0]        nv_page_i,              // Stored page, 30h at LSB.
  input  wire logic               temp_valid_i,           // Measurement strobe.
  input  wire logic [7:0]         temp_code_i,            // Measured code.
  output logic                    nv_load_req_o,          // Request page load.
  output logic                    ready_o,                // Fully functional.
  output logic [15:0]             reload_o,               // Timer reload value.
  output rap_pkg::rap_cfg_s       cfg_o,                  // Config fields.
  output rap_pkg::rap_comp_s      comp_o,                 // Compensation values.
  output logic [3:0]              trickle_en_o,           // Resistor switches.
  output logic                    clock_output_pin_en_o,            // Clock output enable.
  output logic                    thermo_run_o,           // Thermometer running.
  output logic                    scan_slow_o,            // 16 s interval chosen.
  output logic                    irq_n_o                 // Interrupt, active low.
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------

  // Three stages; a change counts once stages two and three agree.
  logic [2:0] bk_sync;
  logic [2:0] l1_sync;
  logic [2:0] l2_sync;
  logic [2:0] ok_sync;
  logic       backup;
  logic       low_one;
  logic       low_two;
  logic       supply_ok;

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bk_sync <= 3'h0;
      l1_sync <= 3'h0;
      l2_sync <= 3'h0;
      ok_sync <= 3'h0;
    end
    else
    begin
      bk_sync <= {bk_sync[1:0], backup_mode_i};
      l1_sync <= {l1_sync[1:0], low_one_i};
      l2_sync <= {l2_sync[1:0], low_two_i};
      ok_sync <= {ok_sync[1:0], supply_ok_i};
    end
  end

  // Filtered levels update only when the last two stages agree.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      backup    <= 1'b0;
      low_one   <= 1'b0;
      low_two   <= 1'b0;
      supply_ok <= 1'b0;
    end
    else
    begin
      if (bk_sync[1] == bk_sync[2])
        backup <= bk_sync[2];
      if (l1_sync[1] == l1_sync[2])
        low_one <= l1_sync[2];
      if (l2_sync[1] == l2_sync[2])
        low_two <= l2_sync[2];
      if (ok_sync[1] == ok_sync[2])
        supply_ok <= ok_sync[2];
    end
  end

  // --------------------------------------------------------------------------
  // Power-up sequencing
  // --------------------------------------------------------------------------

  rap_pkg::rap_pwr_e pwr_state;

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      pwr_state <= rap_pkg::PWR_WAIT;
    else
    begin
      unique case (pwr_state)
        rap_pkg::PWR_WAIT:
          if (supply_ok)
            pwr_state <= rap_pkg::PWR_LOAD;
        rap_pkg::PWR_LOAD:
          if (nv_load_i)
            pwr_state <= rap_pkg::PWR_RUN;
        rap_pkg::PWR_RUN:
          pwr_state <= rap_pkg::PWR_RUN;
      endcase
    end
  end

  logic loading;
  logic running;
  assign loading       = (pwr_state == rap_pkg::PWR_LOAD) && nv_load_i;
  assign running       = (pwr_state == rap_pkg::PWR_RUN);
  assign nv_load_req_o = (pwr_state == rap_pkg::PWR_LOAD);
  assign ready_o       = running;

  // --------------------------------------------------------------------------
  // Host access qualification
  // --------------------------------------------------------------------------

  logic host_ok;
  logic wr_en;
  assign host_ok = running && !backup;
  assign wr_en   = host_ok && host_i.wr;

  // Write strobe for a given address.
  function automatic logic hit(input logic [7:0] a);
    hit = wr_en && (host_i.addr == a);
  endfunction : hit

  // --------------------------------------------------------------------------
  // Timer reload bytes
  // --------------------------------------------------------------------------

  logic [7:0] reload_low;
  logic [7:0] reload_high;

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      reload_low  <= rap_pkg::RESET_BYTE;
      reload_high <= rap_pkg::RESET_BYTE;
    end
    else
    begin
      if (hit(rap_pkg::ADDR_RELOAD_LOW))
        reload_low <= host_i.wdata;
      if (hit(rap_pkg::ADDR_RELOAD_HIGH))
        reload_high <= host_i.wdata;
    end
  end

  assign reload_o = {reload_high, reload_low};

  // --------------------------------------------------------------------------
  // Non-volatile configuration page and user bytes
  // --------------------------------------------------------------------------

  logic [7:0] nv_config;
  logic [7:0] xtal_offset;
  logic [7:0] xtal_coef;
  logic [7:0] xtal_turn;
  logic [7:0] nv_user [2];

  // Page loads at power-up; later host writes overwrite the image.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      nv_config   <= rap_pkg::RESET_BYTE;
      xtal_offset <= rap_pkg::RESET_BYTE;
      xtal_coef   <= rap_pkg::RESET_BYTE;
      xtal_turn   <= rap_pkg::RESET_BYTE;
    end
    else if (loading)
    begin
      nv_config   <= nv_page_i[7:0];
      xtal_offset <= nv_page_i[15:8];
      xtal_coef   <= nv_page_i[23:16];
      xtal_turn   <= nv_page_i[31:24] & rap_pkg::TURNOVER_MASK;
    end
    else
    begin
      if (hit(rap_pkg::ADDR_NV_CONFIG))
        nv_config <= host_i.wdata;
      if (hit(rap_pkg::ADDR_XTAL_OFFSET))
        xtal_offset <= host_i.wdata;
      if (hit(rap_pkg::ADDR_XTAL_COEF))
        xtal_coef <= host_i.wdata;
      if (hit(rap_pkg::ADDR_XTAL_TURN))
        xtal_turn <= host_i.wdata & rap_pkg::TURNOVER_MASK;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      nv_user[0] <= rap_pkg::RESET_BYTE;
      nv_user[1] <= rap_pkg::RESET_BYTE;
    end
    else
    begin
      if (hit(rap_pkg::ADDR_NV_USER_0))
        nv_user[0] <= host_i.wdata;
      if (hit(rap_pkg::ADDR_NV_USER_1))
        nv_user[1] <= host_i.wdata;
    end
  end

  // Field decode of the configuration byte.
  always_comb
  begin
    cfg_o.trickle_res = nv_config[rap_pkg::CFG_TRICKLE_HI:rap_pkg::CFG_TRICKLE_LO];
    cfg_o.clock_output_pin_freq = nv_config[rap_pkg::CFG_FREQ_HI:rap_pkg::CFG_FREQ_LO];
    cfg_o.thermo_en   = nv_config[rap_pkg::CFG_THERMO_EN];
    cfg_o.scan_slow   = nv_config[rap_pkg::CFG_SCAN_SEL];
  end

  assign comp_o.offset_sign   = xtal_offset[rap_pkg::OFFSET_SIGN_BIT];
  assign comp_o.offset_mag    = xtal_offset[6:0];
  assign comp_o.quad_coef     = xtal_coef;
  assign comp_o.turnover_temp = xtal_turn[5:0];
  assign scan_slow_o          = cfg_o.scan_slow;

  // --------------------------------------------------------------------------
  // Temperature register and cache
  // --------------------------------------------------------------------------

  logic [7:0] temp_value;
  logic [7:0] temp_cache;

  assign thermo_run_o = running && cfg_o.thermo_en && !low_one;

  // offset-60 code from the sensor; cleared to 0 degrees at reset.
  // host write only with thermometer disabled
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      temp_value <= rap_pkg::TEMP_OFFSET;
    else if (cfg_o.thermo_en)
    begin
      if (thermo_run_o && temp_valid_i)
        temp_value <= temp_code_i;
    end
    else if (hit(rap_pkg::ADDR_TEMPERATURE))
      temp_value <= host_i.wdata;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      temp_cache <= rap_pkg::TEMP_OFFSET;
    else if (!host_i.busy)
      temp_cache <= temp_value;
  end

  // --------------------------------------------------------------------------
  // Volatile scratch bytes
  // --------------------------------------------------------------------------

  logic [7:0] scratch [SCRATCH_DEPTH];

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < SCRATCH_DEPTH; i++)
        scratch[i] <= rap_pkg::RESET_BYTE;
    end
    else if (wr_en && host_i.addr >= rap_pkg::ADDR_SCRATCH_BASE
             && host_i.addr <= rap_pkg::ADDR_SCRATCH_LAST)
      scratch[host_i.addr[2:0]] <= host_i.wdata;
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------

  logic [7:0] next_rdata;

  // unmapped and unused bits read zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (host_i.addr >= rap_pkg::ADDR_SCRATCH_BASE
        && host_i.addr <= rap_pkg::ADDR_SCRATCH_LAST)
      next_rdata = scratch[host_i.addr[2:0]];
    else
    begin
      unique case (host_i.addr)
        rap_pkg::ADDR_RELOAD_LOW:  next_rdata = reload_low;
        rap_pkg::ADDR_RELOAD_HIGH: next_rdata = reload_high;
        rap_pkg::ADDR_TEMPERATURE: next_rdata = temp_cache;
        rap_pkg::ADDR_NV_USER_0:   next_rdata = nv_user[0];
        rap_pkg::ADDR_NV_USER_1:   next_rdata = nv_user[1];
        rap_pkg::ADDR_NV_CONFIG:   next_rdata = nv_config;
        rap_pkg::ADDR_XTAL_OFFSET: next_rdata = xtal_offset;
        rap_pkg::ADDR_XTAL_COEF:   next_rdata = xtal_coef;
        rap_pkg::ADDR_XTAL_TURN:   next_rdata = xtal_turn & rap_pkg::TURNOVER_MASK;
        default:                   next_rdata = 8'h00;
      endcase
    end
  end

  // Data is registered; a blocked interface keeps the last read data.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rdata_o <= 8'h00;
    else if (host_ok && host_i.rd)
      rdata_o <= next_rdata;
  end

  // --------------------------------------------------------------------------
  // Supply-mode gating of outputs
  // --------------------------------------------------------------------------

  // charge only with resistor chosen, off on switchover
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      trickle_en_o <= 4'h0;
    else if (backup || !running)
      trickle_en_o <= 4'h0;
    else
      trickle_en_o <= cfg_o.trickle_res;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      clock_output_pin_en_o <= 1'b0;
    else
      clock_output_pin_en_o <= running && !backup;
  end

  // interrupt not gated by backup mode
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      irq_n_o <= 1'b1;
    else
      irq_n_o <= !((low_one && low_one_int_en_i) || (low_two && low_two_int_en_i)
                   || other_irq_i);
  end

endmodule : rap_pages

//--- rap_pages_chk.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Port checker for the auxiliary register pages.
// ----------------------------------------------------------------------------
module rap_pages_chk (
  input wire logic               mclk_i,           // Clock.
  input wire logic               sys_rst_i,        // Async reset, high.
  input wire rap_pkg::rap_host_s host_i,           // Host byte access.
  input wire logic [7:0]         rdata_o,          // Read data.
  input wire logic               backup_mode_i,    // On backup supply.
  input wire logic               low_one_i,        // Below threshold one.
  input wire logic               other_irq_i,      // Other sources.
  input wire logic               low_one_int_en_i, // Threshold one enable.
  input wire logic               low_two_int_en_i, // Threshold two enable.
  input wire logic               nv_load_i,        // Page word valid.
  input wire logic               nv_load_req_o,    // Page load request.
  input wire logic               ready_o,          // Fully functional.
  input wire logic [15:0]        reload_o,         // Timer reload.
  input wire rap_pkg::rap_cfg_s  cfg_o,            // Config fields.
  input wire logic [3:0]         trickle_en_o,     // Resistor switches.
  input wire logic               clock_output_pin_en_o,      // Clock output enable.
  input wire logic               thermo_run_o,     // Thermometer running.
  input wire logic               irq_n_o           // Interrupt, low.
);
  logic [3:0] bk_lo_cnt;
  logic [3:0] bk_hi_cnt;
  logic       wr_ok;

  // The backup pin is filtered, so judge accesses only on a settled level.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bk_lo_cnt <= 4'h0;
      bk_hi_cnt <= 4'h0;
    end
    else
    begin
      bk_lo_cnt <= backup_mode_i ? 4'h0 : bk_lo_cnt + {3'h0, bk_lo_cnt != 4'hf};
      bk_hi_cnt <= !backup_mode_i ? 4'h0 : bk_hi_cnt + {3'h0, bk_hi_cnt != 4'hf};
    end
  end

  assign wr_ok = host_i.wr && ready_o && (bk_lo_cnt == 4'hf);

  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  reload_low_a: assert property (wr_ok && host_i.addr == 8'h18
    |=> reload_o[7:0] == $past(host_i.wdata)) else $error("reload low byte wrong");
  reload_high_a: assert property (wr_ok && host_i.addr == 8'h19
    |=> reload_o[15:8] == $past(host_i.wdata) && $stable(reload_o[7:0]))
    else $error("reload high byte wrong");
  cfg_fields_a: assert property (wr_ok && host_i.addr == 8'h30
    |=> cfg_o == $past(host_i.wdata)) else $error("config fields wrong");
  load_ready_a: assert property (nv_load_req_o && nv_load_i |=> ready_o)
    else $error("no run after page load");
  backup_off_a: assert property (bk_hi_cnt >= 4'h8
    |-> trickle_en_o == 4'h0 && !clock_output_pin_en_o) else $error("output live on backup");
  backup_refuse_a: assert property (bk_hi_cnt >= 4'h8 && host_i.wr
    |=> $stable(reload_o) && $stable(cfg_o)) else $error("access taken on backup");
  trickle_sel_a: assert property (ready_o && $past(ready_o) && bk_lo_cnt == 4'hf
    |-> trickle_en_o == $past(cfg_o.trickle_res)) else $error("trickle mismatch");
  irq_masked_a: assert property ((!other_irq_i && !low_one_int_en_i
    && !low_two_int_en_i)[*2] |-> irq_n_o) else $error("interrupt without source");
  irq_low_a: assert property ((low_one_i && low_one_int_en_i)[*8] |-> !irq_n_o)
    else $error("threshold interrupt missing");
  thermo_gate_a: assert property (thermo_run_o |-> cfg_o.thermo_en)
    else $error("thermometer runs while disabled");
  thermo_low_a: assert property (low_one_i[*8] |-> !thermo_run_o)
    else $error("thermometer runs below threshold");

  cover property (wr_ok && host_i.addr == 8'h18);
  cover property (bk_hi_cnt >= 4'h8 && host_i.wr);
  cover property (!irq_n_o && other_irq_i);
endmodule : rap_pages_chk

//--- rap_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Host side model: one byte access at a time over the internal port.
// ----------------------------------------------------------------------------
module rap_host_model (
  input wire logic          mclk_i,  // Clock.
  input wire logic [7:0]    rdata_i, // Read data from the pages.
  output rap_pkg::rap_host_s host_o  // Byte access request.
);
  initial host_o = '0;

  // Between accesses the lines carry inverted values, never stale ones.
  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk_i);
    host_o <= '{rd: 1'b0, wr: 1'b1, busy: 1'b1, addr: addr, wdata: data};
    @(posedge mclk_i);
    host_o <= '{rd: 1'b0, wr: 1'b0, busy: 1'b0, addr: ~addr, wdata: ~data};
  endtask : write_byte

  // Read data stands until the next read, so it is taken one edge later.
  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
    @(posedge mclk_i);
    host_o <= '{rd: 1'b1, wr: 1'b0, busy: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge mclk_i);
    host_o <= '{rd: 1'b0, wr: 1'b0, busy: 1'b0, addr: ~addr, wdata: 8'hff};
    @(posedge mclk_i);
    data = rdata_i;
  endtask : read_byte
endmodule : rap_host_model

//--- rap_pages_test.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Self-checking bench for the auxiliary register pages.
// ----------------------------------------------------------------------------
module rap_pages_test;
  logic mclk_i, sys_rst_i, backup_mode_i, low_one_i, low_two_i, low_one_int_en_i;
  logic low_two_int_en_i, other_irq_i, supply_ok_i, nv_load_i, temp_valid_i;
  logic [39:0] nv_page_i;
  logic [7:0] temp_code_i, rdata_o, rd;
  logic nv_load_req_o, ready_o, clock_output_pin_en_o, thermo_run_o, scan_slow_o, irq_n_o;
  logic [15:0] reload_o;
  logic [3:0] trickle_en_o;
  rap_pkg::rap_host_s host;
  rap_pkg::rap_cfg_s cfg_o;
  rap_pkg::rap_comp_s comp_o;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] rw_addr [12] = '{8'h18, 8'h19, 8'h28, 8'h29, 8'h31, 8'h32,
                               8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3f};

  rap_pages DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .host_i(host), .rdata_o(rdata_o),
    .backup_mode_i(backup_mode_i), .low_one_i(low_one_i), .low_two_i(low_two_i),
    .low_one_int_en_i(low_one_int_en_i), .low_two_int_en_i(low_two_int_en_i),
    .other_irq_i(other_irq_i), .supply_ok_i(supply_ok_i), .nv_load_i(nv_load_i),
    .nv_page_i(nv_page_i), .temp_valid_i(temp_valid_i), .temp_code_i(temp_code_i),
    .nv_load_req_o(nv_load_req_o), .ready_o(ready_o), .reload_o(reload_o), .cfg_o(cfg_o),
    .comp_o(comp_o), .trickle_en_o(trickle_en_o), .clock_output_pin_en_o(clock_output_pin_en_o),
    .thermo_run_o(thermo_run_o), .scan_slow_o(scan_slow_o), .irq_n_o(irq_n_o));
  rap_host_model u_host (.mclk_i(mclk_i), .rdata_i(rdata_o), .host_o(host));

  // Twenty megahertz clock.
  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask : check

  task automatic give_verdict();
    $display("Checks made %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    u_host.read_byte(addr, rd);
    check("read data", {16'h0, rd}, {16'h0, exp});
  endtask : rd_chk

  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : idle

  // A run of well under a thousand cycles is expected; this cuts a hang.
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  initial
  begin
    {backup_mode_i, low_one_i, low_two_i, low_one_int_en_i, low_two_int_en_i} = 5'h0;
    {other_irq_i, nv_load_i, temp_valid_i, temp_code_i} = 11'h0;
    sys_rst_i = 1'b1;
    supply_ok_i = 1'b1;
    nv_page_i = 40'h00_2a_ff_f9_96;
    idle(20);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 60 && !nv_load_req_o; i++) idle(1);
    nv_load_i <= 1'b1;
    for (int i = 0; i < 60 && !ready_o; i++) idle(1);
    nv_load_i <= 1'b0;
    idle(3);
    check("config", cfg_o, 24'h96);
    check("comp", comp_o, {2'h0, 1'b1, 7'h79, 8'hff, 6'h2a});
    check("trickle", trickle_en_o, 24'h9);
    check("thermo", thermo_run_o, 24'h1);
    rd_chk(8'h20, 8'h3c);
    temp_code_i <= 8'hfa;
    temp_valid_i <= 1'b1;
    idle(1);
    temp_valid_i <= 1'b0;
    idle(2);
    rd_chk(8'h20, 8'hfa);
    u_host.write_byte(8'h20, 8'h11);
    rd_chk(8'h20, 8'hfa);
    // Low timer byte takes every value written, zero included; the values written here are nonzero.
    // nonzero low byte
    foreach (rw_addr[i]) u_host.write_byte(rw_addr[i], rw_addr[i] ^ 8'h5a);
    foreach (rw_addr[i]) rd_chk(rw_addr[i], rw_addr[i] ^ 8'h5a);
    check("reload", reload_o, 24'h4342);
    u_host.write_byte(8'h18, 8'hff);
    idle(1);
    check("reload", reload_o, 24'h43ff);
    u_host.write_byte(8'h33, 8'hff);
    rd_chk(8'h33, 8'h3f);
    u_host.write_byte(8'h31, 8'hf9);
    u_host.write_byte(8'h32, 8'hff);
    u_host.write_byte(8'h33, 8'h2a);
    idle(1);
    check("comp", comp_o, {2'h0, 1'b1, 7'h79, 8'hff, 6'h2a});
    rd_chk(8'h40, 8'h00);
    for (int f = 0; f < 4; f++)
    begin
      u_host.write_byte(8'h30, {4'h0, f[1:0], 2'b01});
      idle(1);
      check("freq", cfg_o.clock_output_pin_freq, f);
      check("scan", scan_slow_o, 24'h1);
    end
    u_host.write_byte(8'h20, 8'h00);
    rd_chk(8'h20, 8'h00);
    u_host.write_byte(8'h30, 8'h02);
    for (int i = 0; i < 2; i++)
    begin
      low_one_i <= (i == 0);
      low_two_i <= (i == 1);
      low_one_int_en_i <= (i == 0);
      low_two_int_en_i <= (i == 1);
      temp_code_i <= 8'h55;
      // Strobe only once the filtered threshold level has settled.
      idle(5);
      temp_valid_i <= (i == 0);
      idle(3);
      temp_valid_i <= 1'b0;
      check("irq", irq_n_o, 24'h0);
      check("thermo", thermo_run_o, i);
      {low_one_int_en_i, low_two_int_en_i} <= 2'b00;
      idle(8);
      check("irq", irq_n_o, 24'h1);
    end
    {low_one_i, low_two_i} <= 2'b00;
    rd_chk(8'h20, 8'h00);
    u_host.write_byte(8'h30, 8'hf2);
    backup_mode_i <= 1'b1;
    idle(8);
    check("trickle", trickle_en_o, 24'h0);
    check("clock_output_pin", clock_output_pin_en_o, 24'h0);
    u_host.write_byte(8'h18, 8'h77);
    other_irq_i <= 1'b1;
    idle(4);
    check("irq", irq_n_o, 24'h0);
    other_irq_i <= 1'b0;
    backup_mode_i <= 1'b0;
    idle(8);
    rd_chk(8'h18, 8'hff);
    check("trickle", trickle_en_o, 24'hf);
    check("clock_output_pin", clock_output_pin_en_o, 24'h1);
    give_verdict();
  end
endmodule : rap_pages_test

bind rap_pages rap_pages_chk u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .host_i(host_i),
  .rdata_o(rdata_o), .backup_mode_i(backup_mode_i), .low_one_i(low_one_i),
  .other_irq_i(other_irq_i), .low_one_int_en_i(low_one_int_en_i),
  .low_two_int_en_i(low_two_int_en_i), .nv_load_i(nv_load_i), .nv_load_req_o(nv_load_req_o),
  .ready_o(ready_o), .reload_o(reload_o), .cfg_o(cfg_o), .trickle_en_o(trickle_en_o),
  .clock_output_pin_en_o(clock_output_pin_en_o), .thermo_run_o(thermo_run_o), .irq_n_o(irq_n_o));
